// file: hdl/tbp_port.sv
/*
 * TDM backplane port: transmit and receive serializers with edge
 * selection, double clock, slot interleave, T1 mapping and bit offset.
 * Assumes backplane clocks far slower than clk (oversampled here).
 */
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module tbp_port
    import tbp_pkg::*;
(
    // System
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Transmit backplane pins
    input  wire logic        tx_bp_clock,
    input  wire logic        tx_bp_frame_pulse,
    input  wire logic        tx_bp_pcm_data,
    input  wire logic        tx_bp_signaling,
    // Receive backplane pins
    input  wire logic        rx_bp_clock,
    input  wire logic        rx_bp_frame_pulse,
    output logic             rx_bp_pcm_data,
    output logic             rx_bp_signaling,
    // Byte streams to and from the framers
    output logic      [7:0]  tx_byte,
    output logic             tx_byte_valid,
    output logic             tx_fbit,
    output logic      [4:0]  tx_chan,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_fbit_in
);
    // Reset release synchroniser
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rst_sync_q <= 2'h0;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Pin synchronisers, two flops each
    logic [5:0] pin_s1_q;
    logic [5:0] pin_s2_q;
    logic [1:0] clk_old_q;       // Previous synced clock levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q  <= 6'h00;
            pin_s2_q  <= 6'h00;
            clk_old_q <= 2'h0;
        end else begin
            pin_s1_q  <= {rx_bp_frame_pulse, rx_bp_clock, tx_bp_signaling,
                          tx_bp_pcm_data, tx_bp_frame_pulse, tx_bp_clock};
            pin_s2_q  <= pin_s1_q;
            clk_old_q <= {pin_s2_q[4], pin_s2_q[0]};
        end
    end
    logic t_rise, t_fall, r_rise, r_fall;
    assign t_rise = pin_s2_q[0] & ~clk_old_q[0];
    assign t_fall = ~pin_s2_q[0] & clk_old_q[0];
    assign r_rise = pin_s2_q[4] & ~clk_old_q[1];
    assign r_fall = ~pin_s2_q[4] & clk_old_q[1];

    // Registers; rate is latched on the first write after reset, other config fields on every write
    logic        e1_select_q;
    tbp_cfg_type tx_cfg_q, rx_cfg_q;
    logic [1:0]  tx_rate_q, rx_rate_q;   // Latched rate codes
    logic [1:0]  rate_set_q;             // Rate has been programmed
    logic [1:0]  tx_rate_d, rx_rate_d;
    logic [6:0]  rx_slot_q;              // Receive slot counter
    logic        tx_lock_q;              // Has seen a frame pulse

    // Decode a config word into its fields
    function automatic tbp_cfg_type unpack_cfg(input logic [31:0] w);
        tbp_cfg_type c;
        c.rate  = w[TBP_F_RATE +: 2];
        c.fe    = w[TBP_F_FE];
        c.de    = w[TBP_F_DE];
        c.double_clock_sel   = w[TBP_F_CMS];
        c.map   = w[TBP_F_MAP];
        c.boen  = w[TBP_F_BOEN];
        c.boff  = w[TBP_F_BOFF +: 3];
        c.tsoff = w[TBP_F_TSOFF +: 7];
        return c;
    endfunction

    // Encode a config back into a word
    function automatic logic [31:0] pack_cfg(input tbp_cfg_type c, input logic [1:0] r);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[TBP_F_RATE +: 2]  = r;
        w[TBP_F_FE]         = c.fe;
        w[TBP_F_DE]         = c.de;
        w[TBP_F_CMS]        = c.double_clock_sel;
        w[TBP_F_MAP]        = c.map;
        w[TBP_F_BOEN]       = c.boen;
        w[TBP_F_BOFF +: 3]  = c.boff;
        w[TBP_F_TSOFF +: 7] = c.tsoff;
        return w;
    endfunction

    logic wb_hit;
    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    tbp_cfg_type wr_cfg;
    assign wr_cfg = unpack_cfg(wb_dat_i);

    // Rate field: first write after reset sticks
    // rate locked until reset
    always_comb begin
        tx_rate_d = tx_rate_q;
        rx_rate_d = rx_rate_q;
        if (wb_hit && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == TBP_OFS_TXCFG && !rate_set_q[0]) tx_rate_d = wr_cfg.rate;
            if (wb_adr_i == TBP_OFS_RXCFG && !rate_set_q[1]) rx_rate_d = wr_cfg.rate;
        end
    end

    // Register writes, single-cycle ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            e1_select_q <= 1'b0;
            tx_cfg_q    <= tbp_cfg_type'(TBP_CFG_RST[16:0]);
            rx_cfg_q    <= tbp_cfg_type'(TBP_CFG_RST[16:0]);
            tx_rate_q   <= TBP_RATE_1M5;
            rx_rate_q   <= TBP_RATE_1M5;
            rate_set_q  <= 2'h0;
            wb_ack_o    <= 1'b0;
        end else begin
            wb_ack_o  <= wb_hit;
            tx_rate_q <= tx_rate_d;
            rx_rate_q <= rx_rate_d;
            if (wb_hit && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == TBP_OFS_GLOBAL) begin
                    e1_select_q <= wb_dat_i[0];
                end else if (wb_adr_i == TBP_OFS_TXCFG) begin
                    tx_cfg_q      <= wr_cfg;
                    rate_set_q[0] <= 1'b1;
                end else if (wb_adr_i == TBP_OFS_RXCFG) begin
                    rx_cfg_q      <= wr_cfg;
                    rate_set_q[1] <= 1'b1;
                end
            end
        end
    end

    // Read mux; unmapped reads give zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wb_dat_o <= 32'h0000_0000;
        else if (wb_hit && !wb_we_i) begin
            if (wb_adr_i == TBP_OFS_GLOBAL) wb_dat_o <= {31'h0, e1_select_q};
            else if (wb_adr_i == TBP_OFS_TXCFG) wb_dat_o <= pack_cfg(tx_cfg_q, tx_rate_q);
            else if (wb_adr_i == TBP_OFS_RXCFG) wb_dat_o <= pack_cfg(rx_cfg_q, rx_rate_q);
            else if (wb_adr_i == TBP_OFS_STATUS) wb_dat_o <= {24'h0, rx_slot_q[6:0], tx_lock_q};
            else wb_dat_o <= 32'h0000_0000;
        end
    end

    // Edge count between pulse and first bit
    // offset code drives edge count
    function automatic logic [4:0] edge_count(input logic double_clock_sel, input logic [2:0] code,
                                              input logic [4:0] b1, input logic [4:0] b2);
        logic [4:0] step;
        // Same step per code at either clock rate; only the base differs
        step = TBP_EDGE_STEP;
        return (double_clock_sel ? b2 : b1) + 5'(code * step);
    endfunction

    // Slots per frame minus one from rate: 24 (T1 at 1.5M), 32/64/128
    function automatic logic [6:0] slot_max(input logic [1:0] rate, input logic e1);
        if (rate == TBP_RATE_1M5 && !e1) return 7'(TBP_T1_CHANNELS - 7'h01);
        if (rate == TBP_RATE_4M0) return 7'h3F;
        if (rate == TBP_RATE_8M1) return 7'h7F;
        return 7'(TBP_SLOTS_2M - 7'h01);
    endfunction

    // Map a wire slot to a channel; bit 5 set means unused
    // interleave lane selects our byte
    function automatic logic [5:0] chan_map(input logic [6:0] slot, input tbp_cfg_type c,
                                            input logic [1:0] rate, input logic e1);
        logic [6:0] s;
        logic [1:0] lanes;
        s     = slot - c.tsoff;
        lanes = (rate == TBP_RATE_8M1) ? 2'h3 : (rate == TBP_RATE_4M0) ? 2'h1 : 2'h0;
        if ((s[1:0] & lanes) != 2'h0) return 6'h20;
        s = (rate == TBP_RATE_8M1) ? {2'h0, s[6:2]} : (rate == TBP_RATE_4M0) ? {1'b0, s[6:1]} : s;
        if (e1 || rate == TBP_RATE_1M5) return {1'b0, s[4:0]};
        if (c.map) return (s[4:0] < TBP_T1_CHANNELS[4:0]) ? {1'b0, s[4:0]} : 6'h20;
        if (s[1:0] == 2'h0) return 6'h20;
        return {1'b0, 5'(s[4:2] * 3'h3 + {1'b0, s[1:0]} - 5'h01)};
    endfunction

    // Transmit: pick edges for frame pulse and data
    // tx edge selection
    logic t_fp_edge, t_d_edge, t_half;
    assign t_fp_edge = tx_cfg_q.fe ? t_rise : t_fall;
    assign t_d_edge  = tx_cfg_q.de ? t_rise : t_fall;
    logic [4:0] tx_wait_q;     // Edges left before first data bit
    logic [1:0] tx_half_q;     // Clock periods within a bit
    logic [2:0] tx_bit_q;
    logic [6:0] tx_slot_q;
    logic [7:0] tx_sh_q;
    logic       tx_reload;     // Frame pulse accepted this cycle
    logic       tx_take;       // Data bit sampled this cycle
    logic [2:0] tx_tbit;       // Bit index being sampled
    logic [6:0] tx_tslot;      // Slot index being sampled
    logic [5:0] tx_ch;
    assign t_half    = ~tx_cfg_q.double_clock_sel | tx_half_q[0];
    assign tx_reload = t_fp_edge & pin_s2_q[1];
    // equal edges: bit 0 rides the pulse edge
    assign tx_take   = tx_reload ? (t_d_edge & ~tx_cfg_q.boen)
                     : (t_d_edge & (tx_wait_q == 5'h00) & t_half & tx_lock_q);
    assign tx_tbit   = tx_reload ? 3'h0 : tx_bit_q;
    assign tx_tslot  = tx_reload ? 7'h00 : tx_slot_q;
    assign tx_ch     = chan_map(tx_tslot, tx_cfg_q, tx_rate_q, e1_select_q);

    // Transmit bit and slot counters
    // reload on every frame pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_wait_q <= 5'h00;
            tx_half_q <= 2'h0;
            tx_bit_q  <= 3'h0;
            tx_slot_q <= 7'h00;
            tx_lock_q <= 1'b0;
        end else if (tx_reload) begin
            // edge delay; the last edge itself samples
            tx_wait_q <= tx_cfg_q.boen ? 5'(edge_count(tx_cfg_q.double_clock_sel, tx_cfg_q.boff,
                         TBP_TX_EDGE_BASE_1X, TBP_TX_EDGE_BASE_2X) - 5'h01) : 5'h00;
            // Double clock: first data edge after a wait samples at once
            tx_half_q <= tx_take ? 2'h0 : {1'b0, tx_cfg_q.double_clock_sel};
            tx_bit_q  <= tx_take ? 3'h1 : 3'h0;
            tx_slot_q <= 7'h00;
            tx_lock_q <= 1'b1;
        end else if ((t_rise || t_fall) && tx_wait_q != 5'h00) begin
            tx_wait_q <= tx_wait_q - 5'h01;
        end else if (t_d_edge && tx_wait_q == 5'h00) begin
            // double clock holds each bit two periods
            tx_half_q <= {1'b0, ~tx_half_q[0] & tx_cfg_q.double_clock_sel};
            if (t_half) begin
                tx_bit_q <= tx_bit_q + 3'h1;
                if (tx_bit_q == 3'h7)
                    tx_slot_q <= (tx_slot_q == slot_max(tx_rate_q, e1_select_q)) ?
                                 7'h00 : tx_slot_q + 7'h01;
            end
        end
    end

    // Transmit shifter, bit 0 first; F-bit capture
    // first wire bit lands in bit 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_q       <= 8'h00;
            tx_byte       <= 8'h00;
            tx_byte_valid <= 1'b0;
            tx_fbit       <= 1'b0;
            tx_chan       <= 5'h00;
        end else begin
            tx_byte_valid <= 1'b0;
            if (tx_take) begin
                tx_sh_q <= {pin_s2_q[2], tx_sh_q[7:1]};
                if (!e1_select_q && tx_rate_q != TBP_RATE_1M5 && tx_cfg_q.map
                    && tx_tslot == 7'(slot_max(tx_rate_q, 1'b1)) && tx_tbit == 3'h7)
                    tx_fbit <= pin_s2_q[2];
                else if (!e1_select_q && tx_tslot == 7'h00 && tx_tbit == 3'h0
                         && (tx_rate_q == TBP_RATE_1M5 || !tx_cfg_q.map))
                    tx_fbit <= pin_s2_q[2];
                if (tx_tbit == 3'h7 && !tx_ch[5]) begin
                    tx_byte       <= {pin_s2_q[2], tx_sh_q[7:1]};
                    tx_byte_valid <= 1'b1;
                    tx_chan       <= tx_ch[4:0];
                end
            end
        end
    end

    // Receive: frame sampled on fe, data updated on de
    // rx edge selection
    logic r_fp_edge, r_d_edge, r_half;
    assign r_fp_edge = rx_cfg_q.fe ? r_rise : r_fall;
    assign r_d_edge  = rx_cfg_q.de ? r_rise : r_fall;
    logic [4:0] rx_wait_q;
    logic [1:0] rx_half_q;
    logic [2:0] rx_bit_q;
    assign r_half = ~rx_cfg_q.double_clock_sel | rx_half_q[0];

    // Serial value for a slot and bit; unused slots give 1
    // F-bit in slot 0 bit 0, else data LSB first
    function automatic logic rx_out(input logic [6:0] slot, input logic [2:0] b);
        logic [5:0] ch;
        ch = chan_map(slot, rx_cfg_q, rx_rate_q, e1_select_q);
        if (!e1_select_q && slot == 7'h00 && b == 3'h0
            && (rx_rate_q == TBP_RATE_1M5 || !rx_cfg_q.map))
            return rx_fbit_in;
        return ch[5] ? 1'b1 : rx_byte[b];
    endfunction

    // Receive counters and serial output
    // reload and offset delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wait_q       <= 5'h00;
            rx_half_q       <= 2'h0;
            rx_bit_q        <= 3'h0;
            rx_slot_q       <= 7'h00;
            rx_bp_pcm_data  <= 1'b0;
            rx_bp_signaling <= 1'b0;
        end else if (r_fp_edge && pin_s2_q[5]) begin
            rx_wait_q <= rx_cfg_q.boen ? 5'(edge_count(rx_cfg_q.double_clock_sel, rx_cfg_q.boff,
                         TBP_RX_EDGE_BASE_1X, TBP_RX_EDGE_BASE_2X) - 5'h01) : 5'h00;
            rx_slot_q <= 7'h00;
            if (r_d_edge && !rx_cfg_q.boen) begin
                // bit 0 leaves on the pulse edge itself
                rx_half_q       <= 2'h0;
                rx_bit_q        <= 3'h1;
                rx_bp_pcm_data  <= rx_out(7'h00, 3'h0);
                rx_bp_signaling <= 1'b0;
            end else begin
                // Double clock: first data edge after a wait updates
                rx_half_q <= {1'b0, rx_cfg_q.double_clock_sel};
                rx_bit_q  <= 3'h0;
            end
        end else if ((r_rise || r_fall) && rx_wait_q != 5'h00) begin
            rx_wait_q <= rx_wait_q - 5'h01;
        end else if (r_d_edge && rx_wait_q == 5'h00) begin
            rx_half_q <= {1'b0, ~rx_half_q[0] & rx_cfg_q.double_clock_sel};
            if (r_half) begin
                rx_bp_pcm_data <= rx_out(rx_slot_q, rx_bit_q);
                rx_bp_signaling <= 1'b0;
                rx_bit_q <= rx_bit_q + 3'h1;
                if (rx_bit_q == 3'h7)
                    rx_slot_q <= (rx_slot_q == slot_max(rx_rate_q, e1_select_q)) ?
                                 7'h00 : rx_slot_q + 7'h01;
            end
        end
    end

    // Checks
    AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    AST_RATE_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
        rate_set_q[0] && $stable(rate_set_q[0]) |=> $stable(tx_rate_q))
        else $error("tx rate changed without reset");
    AST_TX_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
        tx_reload |=> tx_slot_q == 7'h00
        && tx_bit_q == ($past(tx_take) ? 3'h1 : 3'h0))
        else $error("tx counters not reloaded");
    AST_TX_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        t_fp_edge && pin_s2_q[1] && tx_cfg_q.boen && !tx_cfg_q.double_clock_sel && tx_cfg_q.boff == 3'h0
        |=> tx_wait_q == 5'h03) else $error("tx offset not four edges");
    AST_TX_OFF2: assert property (@(posedge clk) disable iff (!rst_n)
        t_fp_edge && pin_s2_q[1] && tx_cfg_q.boen && tx_cfg_q.double_clock_sel && tx_cfg_q.boff == 3'h1
        |=> tx_wait_q == 5'h0A) else $error("tx offset code one wrong");
    AST_RX_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
        r_fp_edge && pin_s2_q[5] |=> rx_slot_q == 7'h00
        && rx_bit_q == ($past(r_d_edge && !rx_cfg_q.boen) ? 3'h1 : 3'h0))
        else $error("rx counters not reloaded");
    AST_RX_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        r_fp_edge && pin_s2_q[5] && rx_cfg_q.boen && !rx_cfg_q.double_clock_sel && rx_cfg_q.boff == 3'h0
        |=> rx_wait_q == 5'h02) else $error("rx offset not three edges");
    AST_SLOT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        tx_slot_q <= slot_max(tx_rate_q, e1_select_q)) else $error("tx slot overrun");
    COV_TX_BYTE: cover property (@(posedge clk) disable iff (!rst_n) tx_byte_valid);
    COV_TX_BOFF: cover property (@(posedge clk) disable iff (!rst_n) tx_wait_q == 5'h01);
    COV_RX_WRAP: cover property (@(posedge clk) disable iff (!rst_n)
        rx_slot_q == 7'h7F ##1 rx_slot_q == 7'h00);
endmodule

// file: inc/tbp_pkg.sv
/*
 * Shared constants and types for the TDM backplane port.
 * Assumes a 20 MHz system clock and a Wishbone classic register bus.
 */
package tbp_pkg;
    // Register byte offsets
    localparam logic [7:0] TBP_OFS_GLOBAL = 8'h00;
    localparam logic [7:0] TBP_OFS_TXCFG  = 8'h04;
    localparam logic [7:0] TBP_OFS_RXCFG  = 8'h08;
    localparam logic [7:0] TBP_OFS_STATUS = 8'h0C;
    // Field positions inside a direction config word
    localparam int TBP_F_RATE  = 0;
    localparam int TBP_F_FE    = 2;
    localparam int TBP_F_DE    = 3;
    localparam int TBP_F_CMS   = 4;
    localparam int TBP_F_MAP   = 5;
    localparam int TBP_F_BOEN  = 6;
    localparam int TBP_F_BOFF  = 8;
    localparam int TBP_F_TSOFF = 16;
    // Reset values
    localparam logic [31:0] TBP_CFG_RST = 32'h0000_0000;
    // Rate codes
    localparam logic [1:0] TBP_RATE_1M5 = 2'h0;
    localparam logic [1:0] TBP_RATE_2M0 = 2'h1;
    localparam logic [1:0] TBP_RATE_4M0 = 2'h2;
    localparam logic [1:0] TBP_RATE_8M1 = 2'h3;
    // Bit-offset edge counts for code 0, single and double clock
    localparam logic [4:0] TBP_TX_EDGE_BASE_1X = 5'h04;
    localparam logic [4:0] TBP_TX_EDGE_BASE_2X = 5'h09;
    localparam logic [4:0] TBP_RX_EDGE_BASE_1X = 5'h03;
    localparam logic [4:0] TBP_RX_EDGE_BASE_2X = 5'h06;
    localparam logic [4:0] TBP_EDGE_STEP       = 5'h02;
    // Frame geometry
    localparam logic [6:0] TBP_T1_CHANNELS = 7'h18;
    localparam logic [6:0] TBP_SLOTS_2M    = 7'h20;

    // Decoded per-direction configuration
    typedef struct packed {
        logic [6:0] tsoff;
        logic [2:0] boff;
        logic       boen;
        logic       map;
        logic       double_clock_sel;
        logic       de;
        logic       fe;
        logic [1:0] rate;
    } tbp_cfg_type;
endpackage

// file: tb/tb.sv
/*
 * Testbench for the backplane port: register access over Wishbone,
 * transmit and receive frames through the partner model.
 * Assumes the package constants and the partner model file.
 */
`timescale 1ns/1ps
module tb;
    import tbp_pkg::*;
    // Clock, reset and bus master state
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, rd;
    logic        ack, rpcm, rsig, tvld, tfb;
    logic [7:0]  tbyte;
    logic [4:0]  tch;
    logic [7:0]  rx_byte = 8'hC5;
    logic        rx_fbit_in = 1'b0;
    logic [63:0] cap;
    wire         tclk, tfp, tpcm, tsig, rclk, rfp;
    // Captured transmit bytes and channels
    logic [7:0]  byte_q[$];
    logic [4:0]  chan_q[$];
    int          n_errors = 0, n_compared = 0, cyc_cnt = 0;

    always #25 clk = ~clk;

    tbp_port tbp_port_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .tx_bp_clock(tclk), .tx_bp_frame_pulse(tfp),
        .tx_bp_pcm_data(tpcm), .tx_bp_signaling(tsig), .rx_bp_clock(rclk),
        .rx_bp_frame_pulse(rfp), .rx_bp_pcm_data(rpcm), .rx_bp_signaling(rsig),
        .tx_byte(tbyte), .tx_byte_valid(tvld), .tx_fbit(tfb), .tx_chan(tch),
        .rx_byte(rx_byte), .rx_fbit_in(rx_fbit_in));

    tbp_far_end tbp_far_end_inst (.tx_bp_clock(tclk), .tx_bp_frame_pulse(tfp),
        .tx_bp_pcm_data(tpcm), .tx_bp_signaling(tsig), .rx_bp_clock(rclk),
        .rx_bp_frame_pulse(rfp), .rx_bp_pcm_data(rpcm));

    // Byte pulses last one cycle, so catch each one here
    always @(posedge clk) begin
        if (tvld === 1'b1) begin
            byte_q.push_back(tbyte);
            chan_q.push_back(tch);
        end
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            n_errors++;
            test_done();
        end
    end

    task test_done;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Classic single cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Reset is the only way to change a rate
    task rst;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        byte_q.delete();
        chan_q.delete();
    endtask

    task setup(input logic [31:0] g, input logic [7:0] ofs, input logic [31:0] cfg);
        rst();
        wb(1'b1, TBP_OFS_GLOBAL, g);
        wb(1'b1, ofs, cfg);
    endtask

    // Send one transmit frame and compare the first n bytes
    task tx_case(input logic [31:0] g, input logic [31:0] cfg, input int lead,
                 input int nb, input logic [63:0] d, input logic [31:0] exp, input int n);
        setup(g, TBP_OFS_TXCFG, cfg);
        tbp_far_end_inst.run(1'b0, cfg[2], lead, cfg[4] ? 4 : 2, nb, d, cap);
        repeat (20) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            chk({24'h0, byte_q[i]}, {24'h0, exp[8*i +: 8]}, "tx byte");
        end
    endtask

    // Capture sixteen receive bits
    task rx_case(input logic [31:0] g, input logic [31:0] cfg, input int lead);
        setup(g, TBP_OFS_RXCFG, cfg);
        tbp_far_end_inst.run(1'b1, cfg[2], lead, cfg[4] ? 4 : 2, 16, 64'h0, cap);
    endtask

    initial begin
        // Every rate code, each behind its own reset
        for (int r = 0; r < 4; r++) begin
            rst();
            wb(1'b0, TBP_OFS_TXCFG, 32'h0);
            chk(rd, TBP_CFG_RST, "tx cfg reset");
            wb(1'b1, TBP_OFS_TXCFG, r);
            wb(1'b1, TBP_OFS_RXCFG, 3 - r);
            wb(1'b0, TBP_OFS_TXCFG, 32'h0);
            chk(rd, r, "tx rate");
            wb(1'b0, TBP_OFS_RXCFG, 32'h0);
            chk(rd, 3 - r, "rx rate");
        end
        // Rate rewrite without reset is not taken
        wb(1'b1, TBP_OFS_TXCFG, 32'h0000_0000);
        wb(1'b0, TBP_OFS_TXCFG, 32'h0);
        chk(rd, 32'h0000_0003, "rate kept");
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        // Transmit frames
        tx_case(32'h1, 32'h0000_000D, 0, 32, 64'h1824_4281, 32'h1824_4281, 4);
        tx_case(32'h1, 32'h0000_000E, 0, 32, 64'h1824_4281, 32'h0000_2481, 2);
        tx_case(32'h1, 32'h0000_0041, 4, 16, 64'h4281, 32'h0000_4281, 2);
        tx_case(32'h1, 32'h0000_0155, 11, 16, 64'h4281, 32'h0000_4281, 2);
        tx_case(32'h0, 32'h0000_000D, 0, 48, 64'h5544_3322_1101, 32'h5533_2211, 4);
        chk({31'h0, tfb}, 32'h1, "framing bit");
        for (int i = 0; i < 4; i++) begin
            chk({27'h0, chan_q[i]}, i, "t1 channel");
        end
        // Status: tx locked, no rx frame since reset
        wb(1'b0, TBP_OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0001, "status after tx");
        // Receive frames
        rx_case(32'h1, 32'h0000_0001, 0);
        chk({16'h0, cap[15:0]}, 32'h0000_C5C5, "rx bits");
        rx_case(32'h1, 32'h0000_0049, 3);
        chk({16'h0, cap[15:0]}, 32'h0000_C5C5, "rx offset single");
        rx_case(32'h1, 32'h0000_015D, 8);
        chk({16'h0, cap[15:0]}, 32'h0000_C5C5, "rx offset double");
        rx_case(32'h0, 32'h0000_0001, 0);
        chk({31'h0, cap[0]}, {31'h0, rx_fbit_in}, "rx framing bit");
        chk({24'h0, cap[15:8]}, {24'h0, rx_byte}, "rx first channel");
        chk({31'h0, rsig}, 32'h0, "rx signaling");
        // Sixteen bits leave the rx slot counter at two, tx unlocked
        wb(1'b0, TBP_OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0004, "status after rx");
        test_done();
    end
endmodule

// file: tb/tbp_far_end.sv
/*
 * Behavioural backplane partner: makes frames on the transmit and
 * receive pins and captures the receive serial data.
 * Assumes the port counts link clock edges; clocks stand still between frames.
 */
`timescale 1ns/1ps
module tbp_far_end (
    // Transmit backplane, driven here
    output logic tx_bp_clock,
    output logic tx_bp_frame_pulse,
    output logic tx_bp_pcm_data,
    output logic tx_bp_signaling,
    // Receive backplane
    output logic rx_bp_clock,
    output logic rx_bp_frame_pulse,
    input  wire logic rx_bp_pcm_data
);
    initial begin
        {tx_bp_clock, tx_bp_frame_pulse, tx_bp_pcm_data, tx_bp_signaling} = 4'h0;
        {rx_bp_clock, rx_bp_frame_pulse} = 2'h0;
    end

    // One frame: edge 0 carries the pulse, data sampled at lead + j*per
    task automatic run(input bit rx, input bit fe, input int lead, input int per,
                       input int nb, input logic [63:0] d, output logic [63:0] q);
        int k;
        int j;
        int total;
        logic lvl;
        begin
            q = 64'h0;
            total = lead + nb * per;
            total = total + total % 2;
            // Idle level puts the first edge on the selected polarity
            lvl = ~fe;
            if (rx) rx_bp_clock = lvl; else tx_bp_clock = lvl;
            #1000;
            // bit 0 first; pulse with bit 0
            tx_bp_pcm_data = d[0];
            if (rx) rx_bp_frame_pulse = 1'b1; else tx_bp_frame_pulse = 1'b1;
            for (k = 0; k < total; k++) begin
                #100 lvl = ~lvl;
                if (rx) rx_bp_clock = lvl; else tx_bp_clock = lvl;
                // change half an edge away from the sampling edge
                #100 rx_bp_frame_pulse = 1'b0;
                tx_bp_frame_pulse = 1'b0;
                // per is two edges single rate, four double rate
                j = (k < lead) ? 0 : (k - lead) / per + 1;
                tx_bp_pcm_data = (j < nb) ? d[j] : ~tx_bp_pcm_data;
                tx_bp_signaling = ~tx_bp_pcm_data;
                if (rx && k > lead && (k - lead - 1) % per == 0) begin
                    j = (k - lead - 1) / per;
                    if (j < nb) q[j] = rx_bp_pcm_data;
                end
            end
            // Released data line shows no stale value
            tx_bp_pcm_data = ~tx_bp_pcm_data;
        end
    endtask
endmodule
